// ### fracn_pll_pkg.sv
// Purpose: shared constants and carriers for the synthesizer frequency control block
// Assumes: serial frames of 31 clocks: write flag, 6 address bits, 24 data bits (msb first)
// Notes:   field positions inside the pump and config registers are local choices
package fracn_pll_pkg;

  // frame geometry
  localparam int          FRAME_BITS  = 31;
  localparam int          ADDR_BITS   = 6;
  localparam int          DATA_BITS   = 24;
  localparam logic [4:0]  ADDR_DONE   = 5'h07;   // write flag plus address received
  localparam logic [4:0]  HOP_EDGE    = 5'h1F;   // 31st serial clock

  // register addresses
  localparam logic [5:0]  ADDR_ENABLE = 6'h01;
  localparam logic [5:0]  ADDR_REFDIV = 6'h03;
  localparam logic [5:0]  ADDR_PGAIN  = 6'h07;
  localparam logic [5:0]  ADDR_PTRIM  = 6'h08;
  localparam logic [5:0]  ADDR_INTW   = 6'h0F;
  localparam logic [5:0]  ADDR_FRACW  = 6'h10;
  localparam logic [5:0]  ADDR_DSMCFG = 6'h12;
  localparam logic [5:0]  ADDR_LDCFG  = 6'h1A;
  localparam logic [5:0]  ADDR_SLIPCF = 6'h1C;

  // field positions
  localparam int BIT_SLIP_EN   = 15;   // enable register
  localparam int BIT_DSM_RUN   = 13;   // enable register
  localparam int BIT_INT_MODE  = 3;    // dsm config register
  localparam int BIT_WIN_UP    = 11;   // lock detect config
  localparam int BIT_WIN_ASYM  = 10;   // lock detect config

  // reset values; modulator released so fractional mode is the default
  localparam logic [15:0] ENABLE_RST  = 16'h2000;
  localparam logic [13:0] REFDIV_RST  = 14'h0001;
  localparam logic [15:0] INTW_RST    = 16'h0024;
  localparam logic [23:0] FRACW_RST   = 24'h00_0000;

  // divider limits
  localparam logic [15:0] INTW_MIN    = 16'h0024;  // 36
  localparam logic [15:0] INTW_MAX    = 16'hFFFD;  // 65533
  localparam logic [16:0] DIV_FLOOR   = 17'h0_0020; // 32

  // pump code carrier
  typedef struct packed {
    logic [4:0] up_gain;   // 125 uA per step
    logic [4:0] dn_gain;
    logic [2:0] up_trim;   // 14.7 uA per step
    logic [2:0] dn_trim;
    logic [3:0] up_leak;   // 28.7 uA per step
    logic [3:0] dn_leak;
  } pump_codes_s;

  typedef enum logic [1:0] {
    SLIP_IDLE = 2'b00,
    SLIP_UP   = 2'b01,
    SLIP_DN   = 2'b10
  } slip_state_e;

endpackage

// ### fracn_pll_freq_program_ctrl.sv
// Purpose: serial-programmed frequency, mode, slip guard and pump code control
// Assumes: serial pins sampled synchronously on CLK_I, SCLK much slower than CLK_I
// Notes:   hop fires on the falling edge of serial clock 31 of a qualifying write
`timescale 1ns/1ps
module fracn_pll_freq_program_ctrl
  import fracn_pll_pkg::*;
(
  // clock and reset
  input  wire logic                      CLK_I,
  input  wire logic                      RST_N_I,
  // serial port
  input  wire logic                      SCLK_I,
  input  wire logic                      SEN_I,
  input  wire logic                      SDI_I,
  output logic                           SDO_O,
  // phase detector status from analog side
  input  wire logic                      VCO_SLOW_I,
  input  wire logic                      VCO_FAST_I,
  input  wire logic                      FREQ_NEAR_I,
  // divider control
  output logic [15:0]                    INT_WORD_O,
  output logic [23:0]                    FRAC_WORD_O,
  output logic [16:0]                    DIV_N_O,
  output logic [13:0]                    REF_DIV_O,
  output logic                           DSM_EN_O,
  output logic                           HOP_O,
  // phase detector and pump control
  output logic                           SLIP_GUARD_EN_O,
  output logic                           PFD_GAIN_MAX_O,
  output logic [3:0]                     SLIP_MAG_O,
  output fracn_pll_pkg::pump_codes_s     PUMP_CODES_O,
  output logic                           WIN_LAG_O,
  output logic                           WIN_LEAD_O
);
  import fracn_pll_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // serial deserializer

  logic              sclk_reg;
  logic [4:0]        bit_cnt_reg;
  logic [30:0]       shift_reg;
  logic [23:0]       rd_shift_reg;
  logic              sdo_reg;
  logic              sclk_rise;
  logic              sclk_fall;
  logic              commit;
  logic              is_write;
  logic [5:0]        frame_addr;
  logic [23:0]       frame_data;

  assign sclk_rise  = SCLK_I & ~sclk_reg;
  assign sclk_fall  = ~SCLK_I & sclk_reg;
  assign is_write   = shift_reg[FRAME_BITS-1];
  assign frame_addr = shift_reg[DATA_BITS +: ADDR_BITS];
  assign frame_data = shift_reg[DATA_BITS-1:0];
  // commit on the falling edge that closes the 31st clock
  assign commit     = SEN_I & sclk_fall & (bit_cnt_reg == HOP_EDGE) & is_write;

  // edge history of the serial clock
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      sclk_reg <= 1'b0;
    else
      sclk_reg <= SCLK_I;
  end

  // bit counter and shifter; dropping SEN aborts a partial frame
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      bit_cnt_reg <= 5'h00;
      shift_reg   <= '0;
    end
    else if (!SEN_I)
      bit_cnt_reg <= 5'h00;
    else if (sclk_rise && bit_cnt_reg != HOP_EDGE)
    begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      shift_reg   <= {shift_reg[29:0], SDI_I};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic [15:0]       enable_reg;
  logic [13:0]       refdiv_reg;
  logic [15:0]       intw_reg;
  logic [23:0]       fracw_reg;
  logic              int_mode_reg;
  logic [1:0]        win_cfg_reg;
  logic [3:0]        slip_mag_reg;
  pump_codes_s       pump_reg;
  logic              frac_mode;
  logic              int_ok;

  // fractional mode needs int-mode clear and modulator released
  assign frac_mode = ~int_mode_reg & enable_reg[BIT_DSM_RUN];
  assign int_ok    = (frame_data[15:0] >= INTW_MIN) && (frame_data[15:0] <= INTW_MAX);

  // plain register writes
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      enable_reg   <= ENABLE_RST;
      refdiv_reg   <= REFDIV_RST;
      fracw_reg    <= FRACW_RST;
      int_mode_reg <= 1'b0;
      win_cfg_reg  <= 2'b00;
      slip_mag_reg <= 4'h0;
      pump_reg     <= '0;
    end
    else if (commit)
    begin
      case (frame_addr)
        ADDR_ENABLE: enable_reg   <= frame_data[15:0];
        ADDR_REFDIV: refdiv_reg   <= frame_data[13:0];
        ADDR_FRACW:  fracw_reg    <= frame_data;
        ADDR_DSMCFG: int_mode_reg <= frame_data[BIT_INT_MODE];
        ADDR_LDCFG:  win_cfg_reg  <= frame_data[BIT_WIN_ASYM +: 2];
        ADDR_SLIPCF: slip_mag_reg <= frame_data[3:0];
        ADDR_PGAIN:
        begin
          pump_reg.up_gain <= frame_data[4:0];
          pump_reg.dn_gain <= frame_data[9:5];
        end
        ADDR_PTRIM:
        begin
          pump_reg.up_trim <= frame_data[2:0];
          pump_reg.dn_trim <= frame_data[5:3];
          pump_reg.up_leak <= frame_data[9:6];
          pump_reg.dn_leak <= frame_data[13:10];
        end
        default: ;
      endcase
    end
  end

  // integer word register; out of range words are ignored
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      intw_reg <= INTW_RST;
    else if (commit && frame_addr == ADDR_INTW && int_ok)
      intw_reg <= frame_data[15:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: data word shifted out msb first on falling serial clocks

  function automatic logic [23:0] read_mux(input logic [5:0] a);
    case (a)
      ADDR_ENABLE: read_mux = {8'h00, enable_reg};
      ADDR_REFDIV: read_mux = {10'h000, refdiv_reg};
      ADDR_PGAIN:  read_mux = {14'h0000, pump_reg.dn_gain, pump_reg.up_gain};
      ADDR_PTRIM:  read_mux = {10'h000, pump_reg.dn_leak, pump_reg.up_leak,
                               pump_reg.dn_trim, pump_reg.up_trim};
      ADDR_INTW:   read_mux = {8'h00, intw_reg};
      ADDR_FRACW:  read_mux = fracw_reg;
      ADDR_DSMCFG: read_mux = {20'h0_0000, int_mode_reg, 3'h0};
      ADDR_LDCFG:  read_mux = {12'h000, win_cfg_reg, 10'h000};
      ADDR_SLIPCF: read_mux = {20'h0_0000, slip_mag_reg};
      default:     read_mux = 24'h00_0000;
    endcase
  endfunction

  // addressed read word; a function result cannot be part-selected directly
  logic [23:0]       rd_word;

  assign rd_word = read_mux(shift_reg[ADDR_BITS-1:0]);

  // load after the address arrives, then shift once per falling clock
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      rd_shift_reg <= 24'h00_0000;
      sdo_reg      <= 1'b0;
    end
    else if (!SEN_I)
      sdo_reg <= 1'b0;
    else if (sclk_fall && bit_cnt_reg == ADDR_DONE && !shift_reg[ADDR_BITS])
    begin
      rd_shift_reg <= {rd_word[22:0], 1'b0};
      sdo_reg      <= rd_word[23];
    end
    else if (sclk_fall && bit_cnt_reg > ADDR_DONE)
    begin
      rd_shift_reg <= {rd_shift_reg[22:0], 1'b0};
      sdo_reg      <= rd_shift_reg[23];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // hop control: held integer word and applied divider words

  logic [15:0]       held_int_reg;
  logic [15:0]       app_int_reg;
  logic [23:0]       app_frac_reg;
  logic              hop_reg;
  logic              frac_hop;
  logic              int_hop;

  assign frac_hop = commit && frame_addr == ADDR_FRACW && frac_mode;
  assign int_hop  = commit && frame_addr == ADDR_INTW && !frac_mode && int_ok;

  // integer writes in fractional mode wait here for the next fraction write
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      held_int_reg <= INTW_RST;
    else if (commit && frame_addr == ADDR_INTW && int_ok)
      held_int_reg <= frame_data[15:0];
  end

  // on a fraction write in fractional mode both words move in the same cycle so no mixed frequency appears
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      app_int_reg  <= INTW_RST;
      app_frac_reg <= FRACW_RST;
    end
    else if (frac_hop)
    begin
      app_int_reg  <= held_int_reg;
      app_frac_reg <= frame_data;
    end
    else if (int_hop)
      app_int_reg  <= frame_data[15:0];
  end

  // one-cycle hop strobe
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      hop_reg <= 1'b0;
    else
      hop_reg <= frac_hop | int_hop;
  end

  ////////////////////////////////////////////////////////////////////////////
  // slip guard: temporary divide offset during acquisition

  slip_state_e       slip_reg;
  slip_state_e       slip_next;
  logic [16:0]       div_n_reg;
  logic [16:0]       div_n_next;
  logic              slip_en;

  assign slip_en = enable_reg[BIT_SLIP_EN];

  // floor the divide ratio; small targets lose slip authority here
  function automatic logic [16:0] floor_div(input logic [16:0] n);
    floor_div = (n < DIV_FLOOR) ? DIV_FLOOR : n;
  endfunction

  // pick offset direction from which side the divided vco sits
  always_comb
  begin
    slip_next = SLIP_IDLE;
    if (slip_en && !FREQ_NEAR_I)
    begin
      if (VCO_SLOW_I)
        slip_next = SLIP_DN;
      else if (VCO_FAST_I)
        slip_next = SLIP_UP;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      slip_reg <= SLIP_IDLE;
    else
      slip_reg <= slip_next;
  end

  // slow vco needs a smaller N, fast vco a larger one
  always_comb
  begin
    case (slip_next)
      SLIP_UP: div_n_next = floor_div({1'b0, app_int_reg} + {13'h0000, slip_mag_reg});
      SLIP_DN: div_n_next = floor_div({1'b0, app_int_reg} - {13'h0000, slip_mag_reg});
      default: div_n_next = floor_div({1'b0, app_int_reg});
    endcase
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      div_n_reg <= {1'b0, INTW_RST};
    else
      div_n_reg <= div_n_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  logic              dsm_en_reg;
  logic              win_lag_reg;
  logic              win_lead_reg;

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      dsm_en_reg   <= 1'b1;
      win_lag_reg  <= 1'b0;
      win_lead_reg <= 1'b0;
    end
    else
    begin
      dsm_en_reg   <= frac_mode;
      win_lag_reg  <= win_cfg_reg[0] & win_cfg_reg[1];
      win_lead_reg <= win_cfg_reg[0] & ~win_cfg_reg[1];
    end
  end

  assign SDO_O           = sdo_reg;
  assign INT_WORD_O      = app_int_reg;
  assign FRAC_WORD_O     = app_frac_reg;
  assign DIV_N_O         = div_n_reg;
  assign REF_DIV_O       = refdiv_reg;
  assign DSM_EN_O        = dsm_en_reg;
  assign HOP_O           = hop_reg;
  assign SLIP_GUARD_EN_O = enable_reg[BIT_SLIP_EN];
  assign PFD_GAIN_MAX_O  = (slip_reg != SLIP_IDLE);
  assign SLIP_MAG_O      = slip_mag_reg;
  assign PUMP_CODES_O    = pump_reg;
  assign WIN_LAG_O       = win_lag_reg;
  assign WIN_LEAD_O      = win_lead_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  floor_div_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    DIV_N_O >= DIV_FLOOR)
    else $error("divider below floor");

  slip_gate_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !enable_reg[BIT_SLIP_EN] |=> !PFD_GAIN_MAX_O)
    else $error("slip guard active while disabled");

  slip_down_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (slip_en && !FREQ_NEAR_I && VCO_SLOW_I && app_int_reg > 16'h0040 && !frac_hop && !int_hop)
    |=> DIV_N_O == {1'b0, $past(app_int_reg)} - {13'h0000, $past(slip_mag_reg)})
    else $error("slow vco did not lower N");

  frac_hop_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    frac_hop |=> HOP_O && INT_WORD_O == $past(held_int_reg)
      && FRAC_WORD_O == $past(frame_data))
    else $error("fractional hop words not loaded together");

  int_hold_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (commit && frame_addr == ADDR_INTW && frac_mode) |=> $stable(INT_WORD_O) && !HOP_O)
    else $error("integer write applied in fractional mode");

  int_hop_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    int_hop |=> HOP_O && INT_WORD_O == $past(frame_data[15:0]))
    else $error("integer mode hop missing");

  hop_edge_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    HOP_O |-> $past(sclk_fall) && $past(bit_cnt_reg) == HOP_EDGE)
    else $error("hop outside serial clock 31 fall");

  range_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (commit && frame_addr == ADDR_INTW && !int_ok) |=> $stable(intw_reg))
    else $error("out of range integer word accepted");

  dsm_mode_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    ##1 DSM_EN_O == $past(frac_mode))
    else $error("modulator enable disagrees with mode");

  window_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !(WIN_LAG_O && WIN_LEAD_O) and (win_cfg_reg == 2'b11 |=> WIN_LAG_O))
    else $error("lock window shift wrong");

endmodule

// ### serial_host_model.sv
// Purpose: host controller model that drives the serial configuration port
// Assumes: each serial clock stays high for three system clocks and low for six
// Notes:   serial clock stands low and data shows its inverse between frames
`timescale 1ns/1ps
module serial_host_model
(
  // system clock
  input  wire logic clk_i,
  // serial port pins
  output logic      sclk_o,
  output logic      sen_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  import fracn_pll_pkg::*;

  // idle pins at time zero
  initial
  begin
    sclk_o = 1'b0;
    sen_o  = 1'b0;
    sdi_o  = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // one whole frame; read bits are taken before each rise from bit 8 on
  task automatic xfer(input logic wr, input logic [ADDR_BITS-1:0] addr,
                      input logic [DATA_BITS-1:0] data, output logic [DATA_BITS-1:0] rd);
    logic [FRAME_BITS-1:0] frame;
    frame = {wr, addr, data};
    rd = '0;
    @(posedge clk_i);
    sen_o <= 1'b1;
    for (int i = FRAME_BITS - 1; i >= 0; i--)
    begin
      if (i < DATA_BITS)
        rd = {rd[DATA_BITS-2:0], sdo_i};
      sdi_o <= frame[i];
      wait_clk(3);
      sclk_o <= 1'b1;
      wait_clk(3);
      sclk_o <= 1'b0;
      wait_clk(3);
    end
    // enable held past the last fall so the commit edge sees a whole frame
    sen_o <= 1'b0;
    sdi_o <= ~frame[0];
    wait_clk(3);
  endtask
endmodule

// ### fracn_pll_freq_program_ctrl_tb.sv
// Purpose: self-checking bench for the frequency control block
// Assumes: host model frames; slip inputs driven directly by the bench
// Notes:   hop pulses are counted by a monitor and compared with expectations
`timescale 1ns/1ps
`define CHK(got, exp) check_val(32'(got), 32'(exp))
module fracn_pll_freq_program_ctrl_tb;
  import fracn_pll_pkg::*;

  logic        clk, rst_n, sclk, sen, sdi, sdo, vco_slow, vco_fast, freq_near;
  logic        dsm_en, hop, slip_en, gain_max, win_lag, win_lead, hop_q;
  logic [15:0] int_word, exp_int;
  logic [23:0] frac_word, rdata;
  logic [16:0] div_n;
  logic [13:0] ref_div;
  logic [3:0]  slip_mag;
  pump_codes_s pump;
  int          num_errors, n_checks, hop_hi, hop_rise, exp_hops;
  // small stimulus tables
  logic [23:0] win_d [3] = '{24'h00_0C00, 24'h00_0400, 24'h00_0800};
  logic [2:0]  slip_in [5] = '{3'b100, 3'b010, 3'b101, 3'b110, 3'b000};
  logic [16:0] slip_n [5] = '{17'h0_005A, 17'h0_006E, 17'h0_0064, 17'h0_005A, 17'h0_0064};
  logic [15:0] int_try [4] = '{16'h0023, 16'h0024, 16'hFFFE, 16'hFFFD};

  fracn_pll_freq_program_ctrl dut_u (
    .CLK_I(clk), .RST_N_I(rst_n), .SCLK_I(sclk), .SEN_I(sen), .SDI_I(sdi), .SDO_O(sdo),
    .VCO_SLOW_I(vco_slow), .VCO_FAST_I(vco_fast), .FREQ_NEAR_I(freq_near),
    .INT_WORD_O(int_word), .FRAC_WORD_O(frac_word), .DIV_N_O(div_n), .REF_DIV_O(ref_div),
    .DSM_EN_O(dsm_en), .HOP_O(hop), .SLIP_GUARD_EN_O(slip_en), .PFD_GAIN_MAX_O(gain_max),
    .SLIP_MAG_O(slip_mag), .PUMP_CODES_O(pump), .WIN_LAG_O(win_lag), .WIN_LEAD_O(win_lead)
  );

  serial_host_model host_u (
    .clk_i(clk), .sclk_o(sclk), .sen_o(sen), .sdi_o(sdi), .sdo_i(sdo)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hop monitor; high cycles equal to rises means one-cycle pulses
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk)
  begin
    hop_q <= hop;
    if (hop === 1'b1) hop_hi++;
    if (hop === 1'b1 && hop_q !== 1'b1) hop_rise++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    logic [23:0] unused;
    host_u.xfer(1'b1, a, d, unused);
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, num_errors);
  endtask

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // watchdog sized well beyond twenty-four frames of about 290 cycles
  initial
  begin
    wait_clk(30000);
    num_errors++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    vco_slow = 1'b0;
    vco_fast = 1'b0;
    freq_near = 1'b0;
    exp_hops = 0;
    wait_clk(16);
    rst_n <= 1'b1;
    wait_clk(1);
    `CHK(int_word, INTW_RST);
    `CHK(frac_word, FRACW_RST);
    `CHK(dsm_en, 1'b1);
    `CHK(div_n, 17'h0_0024);
    end_test("reset");
    // upper bits of the reference divider write are dropped
    wr(ADDR_REFDIV, 24'h00_FFFF);
    `CHK(ref_div, 14'h3FFF);
    host_u.xfer(1'b0, ADDR_REFDIV, 24'h00_0000, rdata);
    `CHK(rdata, 24'h00_3FFF);
    wr(6'h3E, 24'hFF_FFFF);
    host_u.xfer(1'b0, 6'h3E, 24'h00_0000, rdata);
    `CHK(rdata, 24'h00_0000);
    end_test("refdiv");
    // integer word is held in fractional mode until the fraction write
    wr(ADDR_INTW, 24'h00_0064);
    `CHK(int_word, INTW_RST);
    `CHK(hop_rise, exp_hops);
    wr(ADDR_FRACW, 24'hAB_CDEF);
    exp_hops++;
    `CHK(hop_rise, exp_hops);
    `CHK(int_word, 16'h0064);
    `CHK(frac_word, 24'hAB_CDEF);
    `CHK(div_n, 17'h0_0064);
    end_test("frac_hop");
    // leak currents stay under a quarter of the gain currents
    wr(ADDR_PGAIN, 24'h00_015F);
    wr(ADDR_PTRIM, 24'h00_0FD5);
    `CHK(pump.up_gain, 5'h1F);
    `CHK(pump.dn_gain, 5'h0A);
    `CHK(pump.up_trim, 3'h5);
    `CHK(pump.dn_trim, 3'h2);
    `CHK(pump.up_leak, 4'hF);
    `CHK(pump.dn_leak, 4'h3);
    end_test("pump");
    for (int i = 0; i < 3; i++)
    begin
      wr(ADDR_LDCFG, win_d[i]);
      `CHK(win_lag, (i == 0));
      `CHK(win_lead, (i == 1));
    end
    end_test("window");
    // magnitude 10 is within a fifth of N = 100
    wr(ADDR_SLIPCF, 24'h00_000A);
    wr(ADDR_ENABLE, 24'h00_A000);
    `CHK(slip_en, 1'b1);
    `CHK(slip_mag, 4'hA);
    for (int i = 0; i < 5; i++)
    begin
      {vco_slow, vco_fast, freq_near} <= slip_in[i];
      wait_clk(3);
      `CHK(div_n, slip_n[i]);
      `CHK(gain_max, (slip_n[i] != 17'h0_0064));
    end
    vco_slow <= 1'b1;
    wr(ADDR_ENABLE, 24'h00_2000);
    `CHK(slip_en, 1'b0);
    `CHK(div_n, 17'h0_0064);
    `CHK(gain_max, 1'b0);
    vco_slow <= 1'b0;
    end_test("slip");
    // integer mode entered in the documented order
    wr(ADDR_DSMCFG, 24'h00_0008);
    wr(ADDR_ENABLE, 24'h00_0000);
    `CHK(dsm_en, 1'b0);
    exp_int = 16'h0064;
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_INTW, {8'h00, int_try[i]});
      if (i % 2 == 1)
      begin
        exp_hops++;
        exp_int = int_try[i];
      end
      `CHK(hop_rise, exp_hops);
      `CHK(int_word, exp_int);
      `CHK(div_n, {1'b0, exp_int});
    end
    wr(ADDR_FRACW, 24'h12_3456);
    `CHK(hop_rise, exp_hops);
    `CHK(frac_word, 24'hAB_CDEF);
    end_test("int_mode");
    // magnitude 7 is within a fifth of 36 yet reaches below the floor
    wr(ADDR_INTW, 24'h00_0024);
    exp_hops++;
    wr(ADDR_SLIPCF, 24'h00_0007);
    wr(ADDR_ENABLE, 24'h00_8000);
    vco_slow <= 1'b1;
    wait_clk(3);
    `CHK(div_n, DIV_FLOOR);
    `CHK(gain_max, 1'b1);
    vco_slow <= 1'b0;
    `CHK(hop_rise, exp_hops);
    `CHK(hop_hi, hop_rise);
    end_test("floor");
    wrap_up();
  end
endmodule
